// File: logic/irq_prio.sv
/*
 Sixteen source interrupt priority and vectoring controller with an
 AXI4-Lite register slave. Assumes synchronous source flags held by
 their peripherals until software clears them there, and a core that
 pulses irq_ack when it takes the offered vector and reti on return.
*/
`timescale 1ns/1ns
`default_nettype none

module irq_prio (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output var  logic        s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output var  logic        s_wready,
    output var  logic [1:0]  s_bresp,
    output var  logic        s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output var  logic        s_arready,
    output var  logic [31:0] s_rdata,
    output var  logic [1:0]  s_rresp,
    output var  logic        s_rvalid,
    input  wire logic        s_rready,
    input  wire logic        power_fail_irq,
    input  wire logic        external_irq_a,
    input  wire logic        timer_a_overflow,
    input  wire logic        external_irq_b,
    input  wire logic        timer_b_overflow,
    input  wire logic        uart_tx_done,
    input  wire logic        uart_rx_done,
    input  wire logic        timer_c_overflow,
    input  wire logic [7:0]  activity_flags,
    input  wire logic [7:0]  two_wire_a_control_reg,
    input  wire logic        conversion_done_irq,
    input  wire logic [7:0]  two_wire_b_control_reg,
    input  wire logic        keyboard_buffer_irq,
    input  wire logic [7:0]  pm_buffer_a_status_reg,
    input  wire logic [7:0]  key_detect_flags,
    input  wire logic        watchdog_tick_irq,
    input  wire logic [7:0]  pm_buffer_b_status_reg,
    input  wire logic        irq_ack,
    input  wire logic        reti,
    output var  logic        irq_request,
    output var  logic [7:0]  irq_vector,
    output var  logic [1:0]  irq_level,
    output var  logic        irq_out
);

    typedef struct packed {
        logic                 aw_full;
        logic [7:0]           aw_addr;
        logic                 w_full;
        logic [31:0]          w_data;
        logic                 w_lane0;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic [7:0]           base_en;
        logic [7:0]           base_pri;
        logic [7:0]           ext_en;
        logic [7:0]           ext_pri;
        logic                 pf_en;
        logic [2:0]           status;
        logic [2:0]           mask;
        logic [2:0]           in_svc;
        logic                 req;
        irq_prio_pkg::level_t level;
        logic [7:0]           vector;
        logic                 irq;
    } state_t;

    state_t st;
    state_t next_st;

    logic [15:0] src;
    logic [15:0] en;
    logic [15:0] pri;
    logic [15:0] pend;
    logic [15:0] hi_set;
    logic [15:0] lo_set;
    logic        pf_ok;
    logic        hi_ok;
    logic        lo_ok;
    logic        win_valid;
    logic [3:0]  win_idx;
    irq_prio_pkg::level_t win_lvl;
    logic        take;
    logic        do_wr_seen;

    // Source vector in natural order; bit 0 is natural priority 1.
    assign src = {pm_buffer_b_status_reg[1],
                  watchdog_tick_irq,
                  |key_detect_flags,
                  pm_buffer_a_status_reg[1],
                  keyboard_buffer_irq,
                  two_wire_b_control_reg[4],
                  conversion_done_irq,
                  two_wire_a_control_reg[4],
                  |activity_flags,
                  timer_c_overflow,
                  uart_tx_done | uart_rx_done,
                  timer_b_overflow,
                  external_irq_b,
                  timer_a_overflow,
                  external_irq_a,
                  power_fail_irq};

    // Power fail has no priority bit and ignores the global enable.
    assign en  = {st.ext_en, st.base_en[6:0], st.pf_en};
    assign pri = {st.ext_pri, st.base_pri[6:0], 1'b0};
    assign pend = src & en &
                  {{15{st.base_en[irq_prio_pkg::GLOBAL_EN_BIT]}}, 1'b1};
    assign hi_set = pend & pri;
    assign lo_set = pend & ~pri & 16'hfffe;

    // A level may only interrupt routines of a lower level.
    assign pf_ok = pend[0] & ~st.in_svc[2];
    assign hi_ok = (|hi_set) & ~st.in_svc[2] & ~st.in_svc[1];
    assign lo_ok = (|lo_set) & (st.in_svc == 3'h0);
    assign win_valid = pf_ok | hi_ok | lo_ok;
    assign take = st.req & irq_ack;

    // Fixed order search from the lowest natural priority upward so
    // that the smallest index is left standing.
    always_comb begin
        win_idx = 4'h0;
        win_lvl = irq_prio_pkg::LVL_LOW;
        if (pf_ok) begin
            win_lvl = irq_prio_pkg::LVL_PF;
        end else if (hi_ok) begin
            win_lvl = irq_prio_pkg::LVL_HIGH;
            for (int i = 15; i >= 1; i--) begin
                if (hi_set[i]) begin
                    win_idx = 4'(i);
                end
            end
        end else begin
            for (int i = 15; i >= 1; i--) begin
                if (lo_set[i]) begin
                    win_idx = 4'(i);
                end
            end
        end
    end

    // Bus, register and sequencing logic in one next-state process.
    always_comb begin
        logic do_wr;
        logic do_rd;
        logic [2:0] evt;
        logic [2:0] clr;
        logic [7:0] wa;
        next_st = st;
        do_wr = 1'b0;
        do_rd = 1'b0;
        evt = 3'h0;
        clr = 3'h0;
        wa = st.aw_addr;
        // Address and data are latched independently, in any order.
        if (s_awvalid && st.awready) begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = s_awaddr;
        end
        if (s_wvalid && st.wready) begin
            next_st.w_full = 1'b1;
            next_st.w_data = s_wdata;
            next_st.w_lane0 = s_wstrb[0];
        end
        do_wr = st.aw_full && st.w_full && !st.bvalid;
        if (do_wr) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = irq_prio_pkg::RESP_OKAY;
            if (st.w_lane0) begin
                case (wa)
                    irq_prio_pkg::BASE_ENABLE_OFS:
                        next_st.base_en = st.w_data[7:0];
                    irq_prio_pkg::BASE_PRIO_OFS:
                        next_st.base_pri = st.w_data[7:0];
                    irq_prio_pkg::EXT_ENABLE_OFS:
                        next_st.ext_en = st.w_data[7:0];
                    irq_prio_pkg::EXT_PRIO_OFS:
                        next_st.ext_pri = st.w_data[7:0];
                    irq_prio_pkg::PF_ENABLE_OFS:
                        next_st.pf_en = st.w_data[0];
                    irq_prio_pkg::EVT_MASK_OFS:
                        next_st.mask = st.w_data[2:0];
                    irq_prio_pkg::EVT_STATUS_OFS,
                    irq_prio_pkg::STATE_OFS: begin
                    end
                    default:
                        next_st.bresp = irq_prio_pkg::RESP_SLVERR;
                endcase
            end
        end else if (st.bvalid && s_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.awready = !next_st.aw_full;
        next_st.wready = !next_st.w_full;
        // Reads answer one cycle after the address is taken.
        do_rd = s_arvalid && st.arready;
        if (do_rd) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = irq_prio_pkg::RESP_OKAY;
            next_st.rdata = 32'h0;
            case (s_araddr)
                irq_prio_pkg::BASE_ENABLE_OFS:
                    next_st.rdata[7:0] = st.base_en;
                irq_prio_pkg::BASE_PRIO_OFS:
                    next_st.rdata[7:0] = st.base_pri;
                irq_prio_pkg::EXT_ENABLE_OFS:
                    next_st.rdata[7:0] = st.ext_en;
                irq_prio_pkg::EXT_PRIO_OFS:
                    next_st.rdata[7:0] = st.ext_pri;
                irq_prio_pkg::PF_ENABLE_OFS:
                    next_st.rdata[0] = st.pf_en;
                irq_prio_pkg::EVT_STATUS_OFS: begin
                    next_st.rdata[2:0] = st.status;
                    clr = st.status;
                end
                irq_prio_pkg::EVT_MASK_OFS:
                    next_st.rdata[2:0] = st.mask;
                irq_prio_pkg::STATE_OFS:
                    next_st.rdata = {st.vector, 5'h0, st.in_svc,
                                     pend};
                default:
                    next_st.rresp = irq_prio_pkg::RESP_SLVERR;
            endcase
        end else if (st.rvalid && s_rready) begin
            next_st.rvalid = 1'b0;
        end
        next_st.arready = !next_st.rvalid;
        // The core taking a vector marks its level in service.
        if (take) begin
            next_st.in_svc[st.level] = 1'b1;
            evt[irq_prio_pkg::EVT_TAKEN] = 1'b1;
            evt[irq_prio_pkg::EVT_PF_TAKEN] =
                (st.level == irq_prio_pkg::LVL_PF);
            evt[irq_prio_pkg::EVT_PREEMPT] = st.in_svc[0] &&
                (st.level == irq_prio_pkg::LVL_HIGH);
        end else if (reti) begin
            // Return retires the highest level in service.
            if (st.in_svc[2]) begin
                next_st.in_svc[2] = 1'b0;
            end else if (st.in_svc[1]) begin
                next_st.in_svc[1] = 1'b0;
            end else begin
                next_st.in_svc[0] = 1'b0;
            end
        end
        // The offer drops for one cycle after a take so that the new
        // in-service state is seen before the next choice.
        next_st.req = win_valid && !take;
        if (win_valid && !take) begin
            next_st.level = win_lvl;
            next_st.vector = irq_prio_pkg::VECTORS[win_idx];
        end
        // A new event wins over a read clear in the same cycle.
        next_st.status = (st.status & ~clr) | evt;
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // Single register stage for all state; ce freezes everything except reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.base_en <= irq_prio_pkg::REG8_RESET;
            st.status <= irq_prio_pkg::EVT_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign s_awready   = st.awready;
    assign s_wready    = st.wready;
    assign s_bvalid    = st.bvalid;
    assign s_bresp     = st.bresp;
    assign s_arready   = st.arready;
    assign s_rvalid    = st.rvalid;
    assign s_rdata     = st.rdata;
    assign s_rresp     = st.rresp;
    assign irq_request = st.req;
    assign irq_vector  = st.vector;
    assign irq_level   = st.level;
    assign irq_out     = st.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Checks on arbitration, nesting and the register slave.
    pf_wins_a: assert property (ce && pf_ok && !take |=>
        irq_request && irq_level == irq_prio_pkg::LVL_PF)
        else $error("power fail did not win");
    pf_vector_a: assert property (irq_request &&
        irq_level == irq_prio_pkg::LVL_PF |-> irq_vector == 8'h33)
        else $error("power fail vector wrong");
    high_first_a: assert property (ce && hi_ok && !pf_ok && !take
        |=> irq_level == irq_prio_pkg::LVL_HIGH)
        else $error("high level not served first");
    nest_a: assert property (irq_request &&
        irq_level == irq_prio_pkg::LVL_LOW |-> st.in_svc == 3'h0)
        else $error("low request offered during service");
    lowest_wins_a: assert property (ce && lo_ok && !hi_ok &&
        !pf_ok && !take && lo_set[1] |=> irq_vector == 8'h03)
        else $error("tie not resolved to lowest number");
    take_drops_a: assert property (ce && take |=> !irq_request)
        else $error("request stayed up after take");
    irq_line_a: assert property (irq_out == |(st.status & st.mask))
        else $error("interrupt line disagrees with status");
    rd_resp_a: assert property (ce && s_arvalid && s_arready |=>
        s_rvalid) else $error("read answer late");
    wr_resp_a: assert property (ce && do_wr_seen |=> s_bvalid)
        else $error("write answer late");
    evt_wins_a: assert property (ce && take |=>
        st.status[irq_prio_pkg::EVT_TAKEN])
        else $error("taken event lost");

    // Mirrors the write strobe of the next-state process for wr_resp_a.
    assign do_wr_seen = st.aw_full && st.w_full && !st.bvalid;

    // Answers must stand until the master takes them, or data is lost.
    read_hold_a: assert property (s_rvalid && !s_rready |=>
        s_rvalid && $stable(s_rdata)) else $error("read answer dropped");
    write_hold_a: assert property (s_bvalid && !s_bready |=>
        s_bvalid && $stable(s_bresp)) else $error("write answer dropped");
    // A high offer never stands while high or power fail is served.
    hi_nest_a: assert property (irq_request &&
        irq_level == irq_prio_pkg::LVL_HIGH |-> st.in_svc[2:1] == 2'h0)
        else $error("high request offered during service");
    return_retire_a: assert property (ce && reti && !take &&
        st.in_svc[2] |=> !st.in_svc[2])
        else $error("return did not retire power fail level");
    lowest_high_a: assert property (ce && hi_ok && !pf_ok &&
        !take && hi_set[1] |=> irq_vector == 8'h03)
        else $error("high tie not resolved to lowest number");
    status_clear_a: assert property (ce && s_arvalid && s_arready &&
        s_araddr == irq_prio_pkg::EVT_STATUS_OFS && !take |=>
        st.status == 3'h0) else $error("status not cleared by read");

endmodule : irq_prio

`default_nettype wire

// File: logic/irq_prio_pkg.sv
/*
 Constants shared by the interrupt priority controller: register byte
 offsets, reset values, vector addresses and the level encoding.
 Assumes a 32-bit AXI4-Lite register bus with one register per word.
*/
`default_nettype none

package irq_prio_pkg;

    localparam int NUM_SRC = 16;

    // Register byte offsets.
    localparam logic [7:0] BASE_ENABLE_OFS = 8'h00;
    localparam logic [7:0] BASE_PRIO_OFS   = 8'h04;
    localparam logic [7:0] EXT_ENABLE_OFS  = 8'h08;
    localparam logic [7:0] EXT_PRIO_OFS    = 8'h0c;
    localparam logic [7:0] PF_ENABLE_OFS   = 8'h10;
    localparam logic [7:0] EVT_STATUS_OFS  = 8'h14;
    localparam logic [7:0] EVT_MASK_OFS    = 8'h18;
    localparam logic [7:0] STATE_OFS       = 8'h1c;

    // Reset values.
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [2:0] EVT_RESET  = 3'h0;

    // Field positions.
    localparam int GLOBAL_EN_BIT = 7;
    localparam int EVT_TAKEN     = 0;
    localparam int EVT_PF_TAKEN  = 1;
    localparam int EVT_PREEMPT   = 2;

    // Vector per natural priority, index 0 is natural priority 1.
    localparam logic [15:0][7:0] VECTORS = {
        8'h7b, 8'h73, 8'h6b, 8'h63, 8'h5b, 8'h53, 8'h4b, 8'h43,
        8'h3b, 8'h2b, 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03, 8'h33};

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {LVL_LOW, LVL_HIGH, LVL_PF} level_t;

endpackage : irq_prio_pkg

`default_nettype wire

// File: sim/core_model.sv
/*
 Behavioural processor core that takes the offered vector after a lag.
 Assumes the controller holds its offer until the core takes it.
*/
`timescale 1ns/1ns
`default_nettype none

module core_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       irq_request,
    input  wire logic [7:0] irq_vector,
    input  wire logic [1:0] irq_level,
    input  wire logic       accept,
    input  wire logic [1:0] lag,
    output var  logic       irq_ack,
    output var  logic [7:0] got_vec,
    output var  logic [1:0] got_lvl,
    output var  int         takes
);
    int wait_n;

    // A slow core lets the offer stand a few cycles, so a re-evaluated
    // offer is taken with whatever it shows at the taking edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_ack <= 1'b0;
            takes   <= 0;
            wait_n  <= 0;
        end else if (irq_ack && irq_request) begin
            irq_ack <= 1'b0;
            got_vec <= irq_vector;
            got_lvl <= irq_level;
            takes   <= takes + 1;
            wait_n  <= 0;
        end else if (accept && irq_request && !irq_ack) begin
            if (wait_n >= int'(lag)) irq_ack <= 1'b1;
            else wait_n <= wait_n + 1;
        end
    end
endmodule : core_model
`default_nettype wire

// File: sim/sixteen_source_interrupt_priority_tb.sv
/*
 Bench for irq_prio: AXI4-Lite master, source drivers, reference model.
 Assumes core_model stands in for the processor core.
*/
`timescale 1ns/1ns
`default_nettype none

module sixteen_source_interrupt_priority_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, reti = 1'b0, accept = 1'b0;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic        s_arvalid = 1'b0, s_rready = 1'b0;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00, aux = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0]  s_wstrb = 4'hf;
    logic [16:1] fl = '0;
    logic [1:0]  lag = 2'h0, s_bresp, s_rresp, irq_level, got_lvl;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic        irq_request, irq_out, irq_ack;
    logic [7:0]  irq_vector, got_vec;
    int          takes, n_fail = 0, check_count = 0;
    // Model copies of the registers, in-service levels and event status.
    logic [7:0]  ben = 8'h00, bpr = 8'h00, een = 8'h00, epr = 8'h00;
    logic [2:0]  ins = 3'h0, st = 3'h0, msk = 3'h0;
    logic        pfe = 1'b0;
    logic [15:0] rs = 16'h0043;
    logic [7:0]  vec [1:16] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
        8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63, 8'h6b, 8'h73, 8'h7b};

    irq_prio dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .power_fail_irq(fl[1]),
        .external_irq_a(fl[2]), .timer_a_overflow(fl[3]),
        .external_irq_b(fl[4]), .timer_b_overflow(fl[5]),
        .uart_tx_done(fl[6] & aux[0]), .uart_rx_done(fl[6] & ~aux[0]),
        .timer_c_overflow(fl[7]),
        .activity_flags(fl[8] ? 8'h01 << aux[3:1] : 8'h00),
        .two_wire_a_control_reg({aux[7:5], fl[9], aux[3:0]}),
        .conversion_done_irq(fl[10]),
        .two_wire_b_control_reg({aux[7:5], fl[11], aux[3:0]}),
        .keyboard_buffer_irq(fl[12]),
        .pm_buffer_a_status_reg({aux[7:2], fl[13], aux[0]}),
        .key_detect_flags(fl[14] ? 8'h80 >> aux[3:1] : 8'h00),
        .watchdog_tick_irq(fl[15]),
        .pm_buffer_b_status_reg({aux[7:2], fl[16], aux[0]}),
        .irq_ack(irq_ack), .reti(reti), .irq_request(irq_request),
        .irq_vector(irq_vector), .irq_level(irq_level), .irq_out(irq_out));

    core_model core (.aclk(aclk), .aresetn(aresetn),
        .irq_request(irq_request), .irq_vector(irq_vector),
        .irq_level(irq_level), .accept(accept), .lag(lag),
        .irq_ack(irq_ack), .got_vec(got_vec), .got_lvl(got_lvl),
        .takes(takes));

    // Free-running 25 MHz clock.
    always #20 aclk = ~aclk;

    function automatic logic [15:0] rnd();
        rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
        return rs;
    endfunction : rnd

    // Reference arbiter: a level is offered only when nothing at or above
    // it is in service; within a level the lowest number wins.
    function automatic int pick(output logic [1:0] lv);
        logic [14:0] en;
        logic [14:0] hi;
        en = {een, ben[6:0]};
        hi = {epr, bpr[6:0]};
        lv = 2'h2;
        if (fl[1] && pfe && !ins[2]) return 1;
        for (int l = 1; l >= 0; l--) begin
            lv = 2'(l);
            if (ins[2] || ins[1] || (l == 0 && ins[0])) continue;
            for (int n = 2; n <= 16; n++)
                if (fl[n] && ben[7] && en[n-2] && hi[n-2] == l) return n;
        end
        return 0;
    endfunction : pick

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic aw, w, b;
        logic [1:0] r;
        int n;
        b = 1'b0;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= {rnd(), 8'h00, v};
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!b && n < 50) begin
            @(negedge aclk);
            aw = s_awvalid & s_awready;
            w = s_wvalid & s_wready;
            b = s_bvalid;
            r = s_bresp;
            @(posedge aclk);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
            n++;
        end
        s_bready <= 1'b0;
        chk(b, 1'b1);
        chk(r, a > 8'h1c ? 2'h2 : 2'h0);
        // A write without its low byte lane leaves every register alone.
        case (s_wstrb[0] ? a : 8'hff)
            8'h00: ben = v;
            8'h04: bpr = v;
            8'h08: een = v;
            8'h0c: epr = v;
            8'h10: pfe = v[0];
            8'h18: msk = v[2:0];
            default: ;
        endcase
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic h;
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] e;
        logic ar;
        int n;
        h = 1'b0;
        n = 0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!h && n < 50) begin
            @(negedge aclk);
            h = s_rvalid;
            d = s_rdata;
            r = s_rresp;
            ar = s_arvalid & s_arready;
            @(posedge aclk);
            if (ar) s_arvalid <= 1'b0;
            n++;
        end
        s_rready <= 1'b0;
        case (a)
            8'h00: e = ben;
            8'h04: e = bpr;
            8'h08: e = een;
            8'h0c: e = epr;
            8'h10: e = {7'h0, pfe};
            8'h14: e = {5'h0, st};
            8'h18: e = {5'h0, msk};
            default: e = 8'h00;
        endcase
        chk(h, 1'b1);
        chk(r, a > 8'h1c ? 2'h2 : 2'h0);
        if (a != 8'h1c) chk(d, {24'h0, e});
        else chk(d[18:16], ins);
        if (a == 8'h14) st = 3'h0;
    endtask : rd

    task automatic setf(input logic [16:1] f);
        @(posedge aclk);
        fl <= f;
        aux <= 8'(rnd());
    endtask : setf

    // Lets the core take whatever is offered and compares with the model.
    task automatic step;
        int n, t;
        logic [1:0] lv;
        @(posedge aclk);
        n = pick(lv);
        t = takes;
        accept <= 1'b1;
        lag <= 2'(rnd());
        for (int i = 0; i < (n > 0 ? 40 : 10) && takes == t; i++)
            @(negedge aclk);
        @(posedge aclk);
        accept <= 1'b0;
        chk(takes - t, n > 0);
        if (n > 0) begin
            chk(got_vec, vec[n]);
            chk(got_lvl, lv);
            st = st | {lv == 2'h1 && ins[0], lv == 2'h2, 1'b1};
            ins[lv] = 1'b1;
            fl[n] <= 1'b0;
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            chk(irq_out, |(st & msk));
        end
    endtask : step

    task automatic ret;
        @(posedge aclk);
        reti <= 1'b1;
        @(posedge aclk);
        reti <= 1'b0;
        if (ins[2]) ins[2] = 1'b0;
        else if (ins[1]) ins[1] = 1'b0;
        else ins[0] = 1'b0;
    endtask : ret

    task automatic wrap_up;
        $display("checks=%0d failures=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // Main sequence: reset values, vector table, power fail, order, nesting.
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk(irq_request, 1'b0);
        for (int a = 0; a <= 'h24; a += 4) rd(8'(a));
        wr(8'h24, 8'h5a);
        for (int n = 2; n <= 16; n++) begin
            wr(8'h00, n <= 8 ? 8'hff ^ (8'h01 << (n - 2)) : 8'hff);
            wr(8'h08, n > 8 ? 8'hff ^ (8'h01 << (n - 9)) : 8'hff);
            setf(16'h0001 << (n - 1));
            step;
            wr(8'h00, n <= 8 ? 8'h80 | (8'h01 << (n - 2)) : 8'h80);
            wr(8'h08, n > 8 ? 8'h01 << (n - 9) : 8'h00);
            step;
            ret;
        end
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h7f);
        wr(8'h08, 8'hff);
        wr(8'h0c, 8'hff);
        wr(8'h10, 8'h01);
        setf(16'hffff);
        step;
        wr(8'h00, 8'hff);
        step;
        ret;
        step;
        ret;
        for (int k = 0; k < 2; k++) begin
            wr(8'h04, k > 0 ? 8'(rnd()) & 8'h7f : 8'h00);
            wr(8'h0c, k > 0 ? 8'(rnd()) : 8'h00);
            setf(16'hfffe);
            repeat (15) begin
                step;
                ret;
            end
        end
        rd(8'h14);
        wr(8'h04, 8'h00);
        wr(8'h0c, 8'h00);
        wr(8'h18, 8'h07);
        s_wstrb <= 4'he;
        wr(8'h18, 8'h05);
        s_wstrb <= 4'hf;
        rd(8'h18);
        setf(16'h0200);
        step;
        setf(16'h0004);
        step;
        wr(8'h04, 8'h08);
        setf(16'h0014);
        step;
        rd(8'h14);
        rd(8'h1c);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk(irq_out, 1'b0);
        ret;
        step;
        wr(8'h18, 8'h00);
        ret;
        step;
        wrap_up;
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        wrap_up;
    end
endmodule : sixteen_source_interrupt_priority_tb
`default_nettype wire
